// *** dv/pfc_config_bank_assertions.sv ***
module pfc_chk_assertions
  import pfc_pkg::*;
(
  // Clock and command answers
  input wire logic        clk,
  input wire logic        reset,
  input wire logic        cmd_valid,
  input wire logic        rsp_valid,
  input wire logic        invalid_data,
  input wire logic        invalid_cmd,
  // Sequencer
  input wire pfc_fault_t  fault,
  input wire logic        stage_enable,
  input wire logic        ramp_active,
  input wire logic        latched_off,
  input wire logic [15:0] out_overvolt_effective
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  // Command answers and shutdown responses
  chk_rsp_one: assert property (cmd_valid |=> rsp_valid) else $error("missing answer");
  chk_flag_rsp: assert property (invalid_data || invalid_cmd |-> rsp_valid)
    else $error("flag without answer");
  chk_ov_cap: assert property (out_overvolt_effective <= 16'hFFD7) else $error("OV cap");
  chk_inov_off: assert property (fault.in_ov |=> !stage_enable) else $error("in OV on");
  chk_ov_trip: assert property (fault.out_ov && stage_enable |=> !stage_enable) else $error("OV");
  chk_oc_trip: assert property (fault.oc && stage_enable |=> !stage_enable) else $error("OC");
  chk_ot_trip: assert property (fault.ot && stage_enable |=> !stage_enable) else $error("OT");
  chk_latch_off: assert property (latched_off |-> !stage_enable && !ramp_active)
    else $error("latched but on");
  cover property (invalid_data);
  cover property (invalid_cmd);
  cover property (latched_off);
endmodule
bind pfc_config_bank pfc_chk_assertions pfc_chk_assertions_inst (.clk(clk), .reset(reset),
  .cmd_valid(cmd_valid), .rsp_valid(rsp_valid), .invalid_data(invalid_data), .invalid_cmd(invalid_cmd),
  .fault(fault), .stage_enable(stage_enable), .ramp_active(ramp_active), .latched_off(latched_off),
  .out_overvolt_effective(out_overvolt_effective));

// *** dv/pfc_host_model.sv ***
module pfc_host_model
  import pfc_pkg::*;
(
  // Bus side
  input  wire logic clk,
  output logic      cmd_valid,
  output pfc_req_t  cmd
);
  timeunit 1ns;
  timeprecision 1ns;
  // Idle bus
  initial begin
    cmd_valid = 1'h0;
    cmd = '0;
  end
  // One command; caller may send out-of-order pairs and illegal values
  task automatic send(input logic w, input logic [7:0] c, input logic [15:0] d);
    @(negedge clk);
    cmd_valid = 1'h1;
    cmd = '{w, c, d};
    @(negedge clk);
    cmd_valid = 1'h0;
    cmd = ~cmd;
  endtask
endmodule

// *** dv/tb.sv ***
module tb
  import pfc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk, reset, cmd_valid, rsp_valid, invalid_data, invalid_cmd;
  logic        run_request, stage_enable, ramp_active, latched_off;
  logic [15:0] output_setpoint, rsp_rdata, out_overvolt_effective;
  pfc_req_t    cmd;
  pfc_fault_t  fault;
  int          fail_count, num_checks;
  logic [42:0] rows [24];
  pfc_config_bank #(.CYCLES_PER_MS(4)) pfc_config_bank_inst (.clk(clk), .reset(reset),
    .cmd_valid(cmd_valid), .cmd(cmd), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata),
    .invalid_data(invalid_data), .invalid_cmd(invalid_cmd), .output_setpoint(output_setpoint),
    .run_request(run_request), .fault(fault), .stage_enable(stage_enable), .ramp_active(ramp_active),
    .latched_off(latched_off), .out_overvolt_effective(out_overvolt_effective));
  pfc_host_model pfc_host_model_inst (.clk(clk), .cmd_valid(cmd_valid), .cmd(cmd));
  // Clock
  initial begin
    clk = 1'h0;
    forever #50 clk = ~clk;
  end
  // Compare and count
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic results;
    $display("checks=%0d mismatches=%0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // Bounded wait for the stage to come up
  task automatic wait_on;
    int n;
    for (n = 0; n < 300 && stage_enable !== 1'h1; n++) @(negedge clk);
    if (n == 300) begin
      fail_count++;
      results();
    end
  endtask
  // Rows: write, code, data, {invalid_cmd, invalid_data}, read data
  initial begin
    rows = '{{1'h0,8'h41,16'h0,2'h0,16'h00B8}, {1'h0,8'h47,16'h0,2'h0,16'h00F8},
      {1'h0,8'h50,16'h0,2'h0,16'h00B8}, {1'h0,8'h56,16'h0,2'h0,16'h00C0},
      {1'h1,8'h25,16'hC001,2'h1,16'h0}, {1'h1,8'h26,16'hBFFF,2'h0,16'h0},
      {1'h1,8'h25,16'hBFFF,2'h1,16'h0}, {1'h0,8'h26,16'h0,2'h0,16'hBFFF},
      {1'h1,8'h28,16'h01F5,2'h1,16'h0}, {1'h1,8'h36,16'h019B,2'h1,16'h0},
      {1'h1,8'h40,16'hAE66,2'h1,16'h0}, {1'h1,8'h41,16'h00F8,2'h1,16'h0},
      {1'h1,8'h41,16'h0080,2'h0,16'h0}, {1'h0,8'h41,16'h0,2'h0,16'h0080},
      {1'h1,8'h46,16'h02E4,2'h1,16'h0}, {1'h1,8'h4A,16'h0324,2'h1,16'h0},
      {1'h1,8'h4F,16'h0069,2'h1,16'h0}, {1'h1,8'h51,16'h0078,2'h1,16'h0},
      {1'h1,8'h55,16'h0385,2'h1,16'h0}, {1'h1,8'h56,16'h0000,2'h1,16'h0},
      {1'h1,8'h5E,16'hA999,2'h1,16'h0}, {1'h1,8'h5F,16'h9667,2'h1,16'h0},
      {1'h1,8'h60,16'h01F5,2'h1,16'h0}, {1'h0,8'h27,16'h0,2'h2,16'h0}};
    {reset, run_request, fault, output_setpoint} = {1'h1, 1'h0, 4'h0, 16'hC000};
    repeat (12) @(negedge clk);
    reset = 1'h0;
    foreach (rows[i]) begin
      pfc_host_model_inst.send(rows[i][42], rows[i][41:34], rows[i][33:18]);
      chk(rsp_valid, 16'h1);
      chk({invalid_cmd, invalid_data}, rows[i][17:16]);
      chk(rsp_rdata, rows[i][15:0]);
    end
    pfc_host_model_inst.send(1'h1, 8'h61, 16'h000E);
    chk(invalid_data, 16'h1);
    // Setpoint plus headroom caps a high limit
    pfc_host_model_inst.send(1'h1, 8'h40, 16'hFFD7);
    repeat (2) @(negedge clk);
    chk(out_overvolt_effective, 16'hF000);
    // Retry forever on over-current, latch on output OV
    run_request = 1'h1;
    wait_on();
    chk(ramp_active, 16'h1);
    fault = 4'h4;
    repeat (2) @(negedge clk);
    chk({stage_enable, latched_off}, 16'h0);
    fault = 4'h0;
    wait_on();
    fault = 4'h8;
    repeat (2) @(negedge clk);
    chk({stage_enable, latched_off}, 16'h1);
    {run_request, fault} = 5'h0;
    repeat (2) @(negedge clk);
    chk(latched_off, 16'h0);
    // Input over-voltage holds the stage off while present
    run_request = 1'h1;
    wait_on();
    fault = 4'h1;
    repeat (2) @(negedge clk);
    chk(stage_enable, 16'h0);
    results();
  end
endmodule

// *** src/pfc_config_bank.sv ***
// What this block does
// (RULE1) Margin levels held within 9.5 to 12.0 V
// (RULE2) Upper margin stays above lower margin
// (RULE3) Droop accepted from 0 to 50.0 mV/A
// (RULE4) Input on/off 40-46 V, on 2 V above off
// (RULE5) Output OV limit 10.9-15.99 V, above setpoint
// (RULE6) Effective OV limit capped at setpoint plus 3 V
// (RULE7) Response byte: response, retry, zero delay fields
// (RULE8) Retry 000 stays off, 111 restarts repeatedly; a 000 trip with input OV present goes to PFC_OFF, not PFC_LATCH
// (RULE9) Output OV fault shuts down, code 10
// (RULE10) Over-current fault shuts down, code 11
// (RULE11) Over-current fault limit 26-80.4 A, above warning
// (RULE12) Over-current warning 20-74 A, below fault
// (RULE13) Over-temperature fault 25-140 C, above warning
// (RULE14) Over-temperature warning 25-125 C, below fault
// (RULE15) Over-temperature fault shuts down, code 10
// (RULE16) Input OV limit held within 48 to 90 V
// (RULE17) Input OV response fixed; output off meanwhile
// (RULE18) Power-good on 9.2-11.7 V, 1.6 V above off
// (RULE19) Power-good off 7.6-10.1 V, below on level
// (RULE20) Turn-on delay accepted from 0 to 500 ms
// (RULE21) Rise time accepted from 15 to 500 ms
// (RULE22) Bad writes rejected, value kept, invalid data flagged
module pfc_config_bank
  import pfc_pkg::*;
#(
  parameter int CYCLES_PER_MS = MS_CYCLES
) (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        reset,
  // Command port
  input  wire logic        cmd_valid,
  input  wire pfc_req_t    cmd,
  output logic             rsp_valid,
  output logic [15:0]      rsp_rdata,
  output logic             invalid_data,
  output logic             invalid_cmd,
  // Operating inputs
  input  wire logic [15:0] output_setpoint,
  input  wire logic        run_request,
  input  wire pfc_fault_t  fault,
  // Power stage control
  output logic             stage_enable,
  output logic             ramp_active,
  output logic             latched_off,
  output logic [15:0]      out_overvolt_effective
);

  // Stored words
  logic [15:0] margin_high_level;
  logic [15:0] margin_low_level;
  logic [15:0] droop_slope;
  logic [15:0] input_turn_on_level;
  logic [15:0] input_turn_off_level;
  logic [15:0] out_overvolt_limit;
  logic [15:0] overcurrent_fault_limit;
  logic [15:0] overcurrent_warn_limit;
  logic [15:0] overtemp_fault_limit;
  logic [15:0] overtemp_warn_limit;
  logic [15:0] in_overvolt_limit;
  logic [15:0] good_assert_level;
  logic [15:0] good_deassert_level;
  logic [15:0] turn_on_delay;
  logic [15:0] rise_time;
  logic [7:0]  out_overvolt_response;
  logic [7:0]  overcurrent_response;
  logic [7:0]  overtemp_response;

  // Write checking
  logic        known;
  logic        is_byte;
  logic        word_ok;
  logic        byte_ok;
  logic        accept;
  logic        cmd_wr;
  logic [15:0] chk_lo;
  logic [15:0] chk_hi;
  logic [15:0] chk_partner;
  logic [15:0] chk_gap;
  pfc_chk_t    chk_kind;
  logic [15:0] next_rdata;

  // Sequencer
  pfc_state_t  state;
  pfc_state_t  next_state;
  logic [31:0] tick_cnt;
  logic        ms_tick;
  logic [15:0] ms_cnt;
  logic        trip;
  logic        retry_forever;
  logic [16:0] ov_cap;

  // Response byte is valid only with its fixed code, a legal retry and no delay
  function automatic logic resp_legal(input logic [7:0] b, input logic [1:0] code);
    resp_legal = (b[RESP_MSB:RESP_LSB] == code)                                  // RULE7
      && (b[DELAY_MSB:DELAY_LSB] == DELAY_NONE)                                 // RULE7
      && ((b[RETRY_MSB:RETRY_LSB] == RETRY_NONE) || (b[RETRY_MSB:RETRY_LSB] == RETRY_FOREVER)); // RULE8
  endfunction

  assign cmd_wr = cmd_valid && cmd.write;

  // Range and cross-check selection per command
  always_comb begin
    known       = 1'b1;
    is_byte     = 1'b0;
    chk_lo      = ZERO16;
    chk_hi      = ZERO16;
    chk_partner = ZERO16;
    chk_gap     = STRICT_GAP;
    chk_kind    = PFC_CHK_NONE;
    byte_ok     = 1'b0;
    case (cmd.code)
      CODE_MARGIN_HIGH: begin
        chk_lo      = MARGIN_MIN;                                 // RULE1
        chk_hi      = MARGIN_MAX;
        chk_kind    = PFC_CHK_ABOVE;                              // RULE2
        chk_partner = margin_low_level;
      end
      CODE_MARGIN_LOW: begin
        chk_lo      = MARGIN_MIN;                                 // RULE1
        chk_hi      = MARGIN_MAX;
        chk_kind    = PFC_CHK_BELOW;                              // RULE2
        chk_partner = margin_high_level;
      end
      CODE_DROOP: begin
        chk_hi = DROOP_MAX;                                       // RULE3
      end
      CODE_VIN_ON: begin
        chk_lo      = VIN_MIN;                                    // RULE4
        chk_hi      = VIN_MAX;
        chk_kind    = PFC_CHK_ABOVE;
        chk_partner = input_turn_off_level;
        chk_gap     = VIN_GAP;
      end
      CODE_VIN_OFF: begin
        chk_lo      = VIN_MIN;                                    // RULE4
        chk_hi      = VIN_MAX;
        chk_kind    = PFC_CHK_BELOW;
        chk_partner = input_turn_on_level;
        chk_gap     = VIN_GAP;
      end
      CODE_OUT_OV_LIMIT: begin
        chk_lo      = OUT_OV_MIN;                                 // RULE5
        chk_hi      = OUT_OV_MAX;
        chk_kind    = PFC_CHK_ABOVE;
        chk_partner = output_setpoint;
      end
      CODE_OC_FAULT: begin
        chk_lo      = OC_FAULT_MIN;                               // RULE11
        chk_hi      = OC_FAULT_MAX;
        chk_kind    = PFC_CHK_ABOVE;
        chk_partner = overcurrent_warn_limit;
      end
      CODE_OC_WARN: begin
        chk_lo      = OC_WARN_MIN;                                // RULE12
        chk_hi      = OC_WARN_MAX;
        chk_kind    = PFC_CHK_BELOW;
        chk_partner = overcurrent_fault_limit;
      end
      CODE_OT_FAULT: begin
        chk_lo      = OT_MIN;                                     // RULE13
        chk_hi      = OT_FAULT_MAX;
        chk_kind    = PFC_CHK_ABOVE;
        chk_partner = overtemp_warn_limit;
      end
      CODE_OT_WARN: begin
        chk_lo      = OT_MIN;                                     // RULE14
        chk_hi      = OT_WARN_MAX;
        chk_kind    = PFC_CHK_BELOW;
        chk_partner = overtemp_fault_limit;
      end
      CODE_IN_OV_LIMIT: begin
        chk_lo = IN_OV_MIN;                                       // RULE16
        chk_hi = IN_OV_MAX;
      end
      CODE_GOOD_ON: begin
        chk_lo      = GOOD_ON_MIN;                                // RULE18
        chk_hi      = GOOD_ON_MAX;
        chk_kind    = PFC_CHK_ABOVE;
        chk_partner = good_deassert_level;
        chk_gap     = GOOD_GAP;
      end
      CODE_GOOD_OFF: begin
        chk_lo      = GOOD_OFF_MIN;                               // RULE19
        chk_hi      = GOOD_OFF_MAX;
        chk_kind    = PFC_CHK_BELOW;
        chk_partner = good_assert_level;
        chk_gap     = GOOD_GAP;
      end
      CODE_TURN_ON_DELAY: begin
        chk_hi = TIME_MAX;                                        // RULE20
      end
      CODE_RISE: begin
        chk_lo = RISE_MIN;                                        // RULE21
        chk_hi = TIME_MAX;
      end
      CODE_OUT_OV_RESP: begin
        is_byte = 1'b1;
        byte_ok = resp_legal(cmd.wdata[7:0], RESP_SHUTDOWN);      // RULE9
      end
      CODE_OC_RESP: begin
        is_byte = 1'b1;
        byte_ok = resp_legal(cmd.wdata[7:0], RESP_DISABLE);       // RULE10
      end
      CODE_OT_RESP: begin
        is_byte = 1'b1;
        byte_ok = resp_legal(cmd.wdata[7:0], RESP_SHUTDOWN);      // RULE15
      end
      CODE_IN_OV_RESP: begin
        is_byte = 1'b1;
        byte_ok = 1'b0;                                           // RULE17
      end
      default: begin
        known = 1'b0;
      end
    endcase
  end

  // Shared window and ordering check
  pfc_limit_check u_check (
    .value   (cmd.wdata),
    .lo      (chk_lo),
    .hi      (chk_hi),
    .kind    (chk_kind),
    .partner (chk_partner),
    .gap     (chk_gap),
    .ok      (word_ok)
  );

  assign accept = cmd_wr && known && (is_byte ? byte_ok : word_ok); // RULE22

  // Word storage; a rejected write leaves the old value
  always_ff @(posedge clk) begin
    if (reset) begin
      margin_high_level       <= RST_MARGIN_HIGH;
      margin_low_level        <= RST_MARGIN_LOW;
      droop_slope             <= RST_DROOP;
      input_turn_on_level     <= RST_VIN_ON;
      input_turn_off_level    <= RST_VIN_OFF;
      out_overvolt_limit      <= RST_OUT_OV;
      overcurrent_fault_limit <= RST_OC_FAULT;
      overcurrent_warn_limit  <= RST_OC_WARN;
      overtemp_fault_limit    <= RST_OT_FAULT;
      overtemp_warn_limit     <= RST_OT_WARN;
      in_overvolt_limit       <= RST_IN_OV;
      good_assert_level       <= RST_GOOD_ON;
      good_deassert_level     <= RST_GOOD_OFF;
      turn_on_delay           <= RST_TURN_ON_DELAY;
      rise_time               <= RST_RISE;
      out_overvolt_response   <= RST_OUT_OV_RESP;
      overcurrent_response    <= RST_OC_RESP;
      overtemp_response       <= RST_OT_RESP;
    end else if (accept) begin                                    // RULE22
      case (cmd.code)
        CODE_MARGIN_HIGH:  margin_high_level       <= cmd.wdata;
        CODE_MARGIN_LOW:   margin_low_level        <= cmd.wdata;
        CODE_DROOP:        droop_slope             <= cmd.wdata;
        CODE_VIN_ON:       input_turn_on_level     <= cmd.wdata;
        CODE_VIN_OFF:      input_turn_off_level    <= cmd.wdata;
        CODE_OUT_OV_LIMIT: out_overvolt_limit      <= cmd.wdata;
        CODE_OC_FAULT:     overcurrent_fault_limit <= cmd.wdata;
        CODE_OC_WARN:      overcurrent_warn_limit  <= cmd.wdata;
        CODE_OT_FAULT:     overtemp_fault_limit    <= cmd.wdata;
        CODE_OT_WARN:      overtemp_warn_limit     <= cmd.wdata;
        CODE_IN_OV_LIMIT:  in_overvolt_limit       <= cmd.wdata;
        CODE_GOOD_ON:      good_assert_level       <= cmd.wdata;
        CODE_GOOD_OFF:     good_deassert_level     <= cmd.wdata;
        CODE_TURN_ON_DELAY:    turn_on_delay           <= cmd.wdata;
        CODE_RISE:         rise_time               <= cmd.wdata;
        CODE_OUT_OV_RESP:  out_overvolt_response   <= cmd.wdata[7:0];
        CODE_OC_RESP:      overcurrent_response    <= cmd.wdata[7:0];
        CODE_OT_RESP:      overtemp_response       <= cmd.wdata[7:0];
        default:           droop_slope             <= droop_slope;
      endcase
    end
  end

  // Read data selection
  always_comb begin
    case (cmd.code)
      CODE_MARGIN_HIGH:  next_rdata = margin_high_level;
      CODE_MARGIN_LOW:   next_rdata = margin_low_level;
      CODE_DROOP:        next_rdata = droop_slope;
      CODE_VIN_ON:       next_rdata = input_turn_on_level;
      CODE_VIN_OFF:      next_rdata = input_turn_off_level;
      CODE_OUT_OV_LIMIT: next_rdata = out_overvolt_limit;
      CODE_OC_FAULT:     next_rdata = overcurrent_fault_limit;
      CODE_OC_WARN:      next_rdata = overcurrent_warn_limit;
      CODE_OT_FAULT:     next_rdata = overtemp_fault_limit;
      CODE_OT_WARN:      next_rdata = overtemp_warn_limit;
      CODE_IN_OV_LIMIT:  next_rdata = in_overvolt_limit;
      CODE_GOOD_ON:      next_rdata = good_assert_level;
      CODE_GOOD_OFF:     next_rdata = good_deassert_level;
      CODE_TURN_ON_DELAY:    next_rdata = turn_on_delay;
      CODE_RISE:         next_rdata = rise_time;
      CODE_OUT_OV_RESP:  next_rdata = {8'h00, out_overvolt_response};
      CODE_OC_RESP:      next_rdata = {8'h00, overcurrent_response};
      CODE_OT_RESP:      next_rdata = {8'h00, overtemp_response};
      CODE_IN_OV_RESP:   next_rdata = {8'h00, IN_OV_RESP};   // RULE17
      default:           next_rdata = ZERO16;
    endcase
  end

  // Answer and communication flags, one cycle after the command
  always_ff @(posedge clk) begin
    if (reset) begin
      rsp_valid    <= 1'b0;
      rsp_rdata    <= ZERO16;
      invalid_data <= 1'b0;
      invalid_cmd  <= 1'b0;
    end else begin
      rsp_valid    <= cmd_valid;
      rsp_rdata    <= (cmd_valid && !cmd.write) ? next_rdata : ZERO16;
      invalid_data <= cmd_wr && known && !accept;                 // RULE22
      invalid_cmd  <= cmd_valid && !known;
    end
  end

  // Effective OV limit: lowest of stored, setpoint plus headroom, ceiling
  assign ov_cap = {1'b0, output_setpoint} + {1'b0, OUT_OV_HEADROOM};
  always_ff @(posedge clk) begin
    if (reset) begin
      out_overvolt_effective <= RST_OUT_OV;
    end else if (ov_cap < {1'b0, out_overvolt_limit} && ov_cap <= {1'b0, OUT_OV_MAX}) begin
      out_overvolt_effective <= ov_cap[15:0];                     // RULE6
    end else if (out_overvolt_limit > OUT_OV_MAX) begin
      out_overvolt_effective <= OUT_OV_MAX;                       // RULE6
    end else if (ov_cap < {1'b0, out_overvolt_limit}) begin
      out_overvolt_effective <= OUT_OV_MAX;
    end else begin
      out_overvolt_effective <= out_overvolt_limit;
    end
  end

  // Millisecond enable for the start-up timers
  always_ff @(posedge clk) begin
    if (reset || tick_cnt == 32'(CYCLES_PER_MS - 1)) begin
      tick_cnt <= 32'h0;
    end else begin
      tick_cnt <= tick_cnt + 32'h1;
    end
  end
  assign ms_tick = (tick_cnt == 32'(CYCLES_PER_MS - 1));

  // Any shutdown fault; retry policy taken from the tripping fault's byte
  assign trip = fault.out_ov || fault.oc || fault.ot;
  always_comb begin
    retry_forever = 1'b1;
    if (fault.out_ov && out_overvolt_response[RETRY_MSB:RETRY_LSB] == RETRY_NONE) begin
      retry_forever = 1'b0;                                       // RULE9
    end
    if (fault.oc && overcurrent_response[RETRY_MSB:RETRY_LSB] == RETRY_NONE) begin
      retry_forever = 1'b0;                                       // RULE10
    end
    if (fault.ot && overtemp_response[RETRY_MSB:RETRY_LSB] == RETRY_NONE) begin
      retry_forever = 1'b0;                                       // RULE15
    end
  end

  // Start-up sequencer with fault shutdown and retry
  always_comb begin
    next_state = state;
    case (state)
      PFC_OFF:   if (run_request && !trip && !fault.in_ov) next_state = PFC_DELAY;
      PFC_DELAY: if (ms_tick && ms_cnt >= turn_on_delay) next_state = PFC_RISE;
      PFC_RISE:  if (ms_tick && ms_cnt >= rise_time) next_state = PFC_ON;
      PFC_ON:    next_state = PFC_ON;
      PFC_LATCH: if (!run_request) next_state = PFC_OFF;          // RULE8
      default:   next_state = PFC_OFF;
    endcase
    if (state != PFC_OFF && state != PFC_LATCH) begin
      if (!run_request || fault.in_ov) begin
        next_state = PFC_OFF;                                     // RULE17
      end else if (trip) begin
        next_state = retry_forever ? PFC_OFF : PFC_LATCH;         // RULE8
      end
    end
  end

  // State and millisecond count within a phase
  always_ff @(posedge clk) begin
    if (reset) begin
      state  <= PFC_OFF;
      ms_cnt <= ZERO16;
    end else begin
      state <= next_state;
      if (next_state != state) begin
        ms_cnt <= ZERO16;
      end else if (ms_tick && ms_cnt != 16'hFFFF) begin
        ms_cnt <= ms_cnt + 16'h1;
      end
    end
  end

  // Stage control outputs
  always_ff @(posedge clk) begin
    if (reset) begin
      stage_enable <= 1'b0;
      ramp_active  <= 1'b0;
      latched_off  <= 1'b0;
    end else begin
      stage_enable <= (next_state == PFC_RISE) || (next_state == PFC_ON);
      ramp_active  <= (next_state == PFC_RISE);
      latched_off  <= (next_state == PFC_LATCH);
    end
  end

endmodule

// *** src/pfc_limit_check.sv ***
module pfc_limit_check
  import pfc_pkg::*;
(
  // Candidate and its limits
  input  wire logic [15:0] value,
  input  wire logic [15:0] lo,
  input  wire logic [15:0] hi,
  // Paired value and required spacing
  input  wire pfc_chk_t    kind,
  input  wire logic [15:0] partner,
  input  wire logic [15:0] gap,
  // Verdict
  output logic             ok
);

  logic [16:0] value_gap;
  logic [16:0] partner_gap;
  logic        pair_ok;

  // Widened sums so a large gap cannot wrap
  assign value_gap   = {1'b0, value} + {1'b0, gap};
  assign partner_gap = {1'b0, partner} + {1'b0, gap};

  // Ordering against the paired value
  always_comb begin
    case (kind)
      PFC_CHK_ABOVE: pair_ok = {1'b0, value} >= partner_gap;
      PFC_CHK_BELOW: pair_ok = value_gap <= {1'b0, partner};
      default:       pair_ok = 1'b1;
    endcase
  end

  assign ok = (value >= lo) && (value <= hi) && pair_ok;

endmodule

// *** src/pfc_pkg.sv ***
package pfc_pkg;

  // Command codes of the configuration bank
  localparam logic [7:0] CODE_MARGIN_HIGH   = 8'h25;
  localparam logic [7:0] CODE_MARGIN_LOW    = 8'h26;
  localparam logic [7:0] CODE_DROOP         = 8'h28;
  localparam logic [7:0] CODE_VIN_ON        = 8'h35;
  localparam logic [7:0] CODE_VIN_OFF       = 8'h36;
  localparam logic [7:0] CODE_OUT_OV_LIMIT  = 8'h40;
  localparam logic [7:0] CODE_OUT_OV_RESP   = 8'h41;
  localparam logic [7:0] CODE_OC_FAULT      = 8'h46;
  localparam logic [7:0] CODE_OC_RESP       = 8'h47;
  localparam logic [7:0] CODE_OC_WARN       = 8'h4A;
  localparam logic [7:0] CODE_OT_FAULT      = 8'h4F;
  localparam logic [7:0] CODE_OT_RESP       = 8'h50;
  localparam logic [7:0] CODE_OT_WARN       = 8'h51;
  localparam logic [7:0] CODE_IN_OV_LIMIT   = 8'h55;
  localparam logic [7:0] CODE_IN_OV_RESP    = 8'h56;
  localparam logic [7:0] CODE_GOOD_ON       = 8'h5E;
  localparam logic [7:0] CODE_GOOD_OFF      = 8'h5F;
  localparam logic [7:0] CODE_TURN_ON_DELAY     = 8'h60;
  localparam logic [7:0] CODE_RISE          = 8'h61;

  // Output voltages: unsigned, 1/4096 V per step
  localparam logic [15:0] MARGIN_MAX        = 16'hC000;
  localparam logic [15:0] MARGIN_MIN        = 16'h9800;
  localparam logic [15:0] OUT_OV_MAX        = 16'hFFD7;
  localparam logic [15:0] OUT_OV_MIN        = 16'hAE67;
  localparam logic [15:0] OUT_OV_HEADROOM   = 16'h3000;
  localparam logic [15:0] GOOD_ON_MAX       = 16'hBB33;
  localparam logic [15:0] GOOD_ON_MIN       = 16'h9334;
  localparam logic [15:0] GOOD_OFF_MAX      = 16'hA199;
  localparam logic [15:0] GOOD_OFF_MIN      = 16'h799A;
  localparam logic [15:0] GOOD_GAP          = 16'h199A;
  // Droop 0.1 mV/A, input volts 0.1 V, amps 0.1 A, degrees 1 C, times 1 ms
  localparam logic [15:0] DROOP_MAX         = 16'h01F4;
  localparam logic [15:0] VIN_MAX           = 16'h01CC;
  localparam logic [15:0] VIN_MIN           = 16'h0190;
  localparam logic [15:0] VIN_GAP           = 16'h0014;
  localparam logic [15:0] IN_OV_MAX         = 16'h0384;
  localparam logic [15:0] IN_OV_MIN         = 16'h01E0;
  localparam logic [15:0] OC_FAULT_MAX      = 16'h0324;
  localparam logic [15:0] OC_FAULT_MIN      = 16'h0104;
  localparam logic [15:0] OC_WARN_MAX       = 16'h02E4;
  localparam logic [15:0] OC_WARN_MIN       = 16'h00C8;
  localparam logic [15:0] OT_FAULT_MAX      = 16'h008C;
  localparam logic [15:0] OT_WARN_MAX       = 16'h007D;
  localparam logic [15:0] OT_MIN            = 16'h0019;
  localparam logic [15:0] TIME_MAX          = 16'h01F4;
  localparam logic [15:0] RISE_MIN          = 16'h000F;
  localparam logic [15:0] ZERO16            = 16'h0000;
  localparam logic [15:0] STRICT_GAP        = 16'h0001;

  // Reset values of the words
  localparam logic [15:0] RST_MARGIN_HIGH   = 16'hC000;
  localparam logic [15:0] RST_MARGIN_LOW    = 16'h9800;
  localparam logic [15:0] RST_DROOP         = 16'h0000;
  localparam logic [15:0] RST_VIN_ON        = 16'h01AE;
  localparam logic [15:0] RST_VIN_OFF       = 16'h019A;
  localparam logic [15:0] RST_OUT_OV        = 16'hE000;
  localparam logic [15:0] RST_OC_FAULT      = 16'h0324;
  localparam logic [15:0] RST_OC_WARN       = 16'h02E4;
  localparam logic [15:0] RST_OT_FAULT      = 16'h0078;
  localparam logic [15:0] RST_OT_WARN       = 16'h0069;
  localparam logic [15:0] RST_IN_OV         = 16'h02BC;
  localparam logic [15:0] RST_GOOD_ON       = 16'hB000;
  localparam logic [15:0] RST_GOOD_OFF      = 16'h9000;
  localparam logic [15:0] RST_TURN_ON_DELAY     = 16'h0000;
  localparam logic [15:0] RST_RISE          = 16'h0014;

  // Fault response byte layout
  localparam int          RESP_MSB          = 7;
  localparam int          RESP_LSB          = 6;
  localparam int          RETRY_MSB         = 5;
  localparam int          RETRY_LSB         = 3;
  localparam int          DELAY_MSB         = 2;
  localparam int          DELAY_LSB         = 0;
  localparam logic [1:0]  RESP_SHUTDOWN     = 2'h2;
  localparam logic [1:0]  RESP_DISABLE      = 2'h3;
  localparam logic [2:0]  RETRY_NONE        = 3'h0;
  localparam logic [2:0]  RETRY_FOREVER     = 3'h7;
  localparam logic [2:0]  DELAY_NONE        = 3'h0;
  localparam logic [7:0]  RST_OUT_OV_RESP   = 8'hB8;
  localparam logic [7:0]  RST_OC_RESP       = 8'hF8;
  localparam logic [7:0]  RST_OT_RESP       = 8'hB8;
  localparam logic [7:0]  IN_OV_RESP        = 8'hC0;

  // Timing
  localparam int          CLK_PERIOD_NS     = 100;
  localparam int          MS_NS             = 1000000;
  localparam int          MS_CYCLES         = MS_NS / CLK_PERIOD_NS;

  // Cross-check kinds
  typedef enum logic [1:0] {
    PFC_CHK_NONE  = 2'h0,
    PFC_CHK_ABOVE = 2'h1,
    PFC_CHK_BELOW = 2'h2
  } pfc_chk_t;

  // Sequencer states, Gray along off-delay-rise-on-latched
  typedef enum logic [2:0] {
    PFC_OFF   = 3'h0,
    PFC_DELAY = 3'h1,
    PFC_RISE  = 3'h3,
    PFC_ON    = 3'h2,
    PFC_LATCH = 3'h6
  } pfc_state_t;

  // Host command to the bank
  typedef struct packed {
    logic        write;
    logic [7:0]  code;
    logic [15:0] wdata;
  } pfc_req_t;

  // Live fault conditions
  typedef struct packed {
    logic out_ov;
    logic oc;
    logic ot;
    logic in_ov;
  } pfc_fault_t;

endpackage
